// >>> logic/adc_status_consts.vh
// Constants for the converter status and interrupt block
`ifndef ADC_STATUS_CONSTS_VH
`define ADC_STATUS_CONSTS_VH

`define ADDR_W            32
`define DATA_W            16
`define STATUS_ADDR       32'hffff0500
`define MASK_ADDR         32'hffff0504
`define MODE_ADDR         32'hffff0508
`define CURRENT_ADDR      32'hffff050c
`define VOLTAGE_ADDR      32'hffff0510
`define TEMP_ADDR         32'hffff0514
`define CONFIG_ADDR       32'hffff0518
`define THRESH_ADDR       32'hffff051c
`define TCOUNT_ADDR       32'hffff0520
`define CURCTL_ADDR       32'hffff0524

`define STATUS_RESET      16'h0000
`define MASK_RESET        8'h00
`define BYTE_ZERO         8'h00
`define WORD_ZERO         16'h0000
`define WORD_ONE          16'h0001
`define COUNT_ZERO        8'h00
`define COUNT_ONE         8'h01

`define BIT_CUR_RDY       0
`define BIT_VOL_RDY       1
`define BIT_TMP_RDY       2
`define BIT_OVR           3
`define BIT_CMP           4
`define BIT_CUR_ERR       12
`define BIT_VOL_ERR       13
`define BIT_TMP_ERR       14
`define BIT_CAL           15

`define CFG_CMP_EN        0
`define CFG_CNT_EN        1
`define CFG_OVR_EN        2
`define CTL_GAIN_LSB      0
`define CTL_GAIN_MSB      3

`define POS_FULL          16'h7fff
`define NEG_FULL          16'h8000

`define CLK_HZ            100000000
`define OVR_PERIOD_NS     125000
// Last count of a 12500-cycle period at 10 ns per cycle
`define OVR_LAST          14'h30d3
`define TICK_W            14
`define TICK_ZERO         14'h0000
`define TICK_ONE          14'h0001

`endif

// >>> logic/overrange_tick.v
// Divider giving one enable pulse every overrange sampling period
`timescale 1ns/100ps
`include "adc_status_consts.vh"
module overrange_tick (
	input  wire clk,
	input  wire resetn,
	output reg  tick
);
	localparam [`TICK_W-1:0] LAST = `OVR_LAST;
	reg [`TICK_W-1:0] count_reg;

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count_reg <= `TICK_ZERO;
			tick      <= 1'b0;
		end else if (count_reg == LAST) begin
			count_reg <= `TICK_ZERO;
			tick      <= 1'b1;
		end else begin
			count_reg <= count_reg + `TICK_ONE;
			tick      <= 1'b0;
		end
	end
endmodule

// >>> logic/result_slot.v
// One result register with ready-gated update, clamping and error flag
`timescale 1ns/100ps
`include "adc_status_consts.vh"
module result_slot (
	input  wire                clk,
	input  wire                resetn,
	input  wire                valid,
	input  wire                over,
	input  wire                under,
	input  wire [`DATA_W-1:0]  sample,
	input  wire                ready_flag,
	input  wire                core_down,
	output wire                accept,
	output reg  [`DATA_W-1:0]  result_reg,
	output reg                 error_reg
);
	// Core asleep bypasses the ready gate so data stays current
	assign accept = valid & (~ready_flag | core_down);

	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			result_reg <= `WORD_ZERO;
			error_reg  <= 1'b0;
		end else if (accept) begin
			if (over)
				result_reg <= `POS_FULL;
			else if (under)
				result_reg <= `NEG_FULL;
			else
				result_reg <= sample;
			error_reg <= over | under;
		end
	end
endmodule

// >>> logic/adc_status_irq_logic.v
// Converter status word, interrupt mask and result handshake
`timescale 1ns/100ps
`include "adc_status_consts.vh"
// How it works
// - Status bits 15 to 8 never interrupt
// - Interrupt is OR of masked low byte
// - Each low source individually maskable
// - Mask matches low byte, resets all zero
// - Current result read clears all ready flags
// - Current disabled: voltage/temperature read clears all
// - New result blocked until ready flag clears
// - Core powered down: results always update
// - Bit 15 calibration done, cleared by mode write
// - Bits 14-12 set on channel range error
// - Range errors clamp result to full scale
// - Error flag clears on next in-range write
// - Bit 4 set when current exceeds threshold
// - Threshold counter gates comparator flag setting
// - Comparator flag clears on reconfigure or disable
// - Bit 3 sampled every 125 us
// - Overrange holds until disabled or gain change
// - Bit 2 temperature ready, also calibration end
// - Temperature ready cleared by temperature/current read
// - Bit 1 voltage ready, cleared by voltage/current read
// - Bit 0 current ready, cleared by current read
module adc_status_irq_logic (
	input  wire                clk,
	input  wire                resetn,
	input  wire [`ADDR_W-1:0]  addr,
	input  wire                rd_en,
	input  wire                wr_en,
	input  wire [`DATA_W-1:0]  wdata,
	output reg  [`DATA_W-1:0]  rdata,
	output reg                 irq,
	input  wire                core_down,
	input  wire                cur_en,
	input  wire                vol_en,
	input  wire                tmp_en,
	input  wire                cur_valid,
	input  wire                cur_over,
	input  wire                cur_under,
	input  wire [`DATA_W-1:0]  cur_sample,
	input  wire                vol_valid,
	input  wire                vol_over,
	input  wire                vol_under,
	input  wire [`DATA_W-1:0]  vol_sample,
	input  wire                tmp_valid,
	input  wire                tmp_over,
	input  wire                tmp_under,
	input  wire [`DATA_W-1:0]  tmp_sample,
	input  wire                cal_done,
	input  wire                fast_over
);
	reg  [7:0]          mask_reg;
	reg  [7:0]          mode_reg;
	reg  [7:0]          config_reg;
	reg  [7:0]          curctl_reg;
	reg  [`DATA_W-1:0]  thresh_reg;
	reg  [7:0]          tcount_reg;
	reg  [7:0]          hits_reg;
	reg                 cur_rdy_reg;
	reg                 vol_rdy_reg;
	reg                 tmp_rdy_reg;
	reg                 cmp_reg;
	reg                 ovr_reg;
	reg                 cal_reg;
	wire                tick;
	wire                cur_acc;
	wire                vol_acc;
	wire                tmp_acc;
	wire [`DATA_W-1:0]  cur_res;
	wire [`DATA_W-1:0]  vol_res;
	wire [`DATA_W-1:0]  tmp_res;
	wire                cur_err;
	wire                vol_err;
	wire                tmp_err;
	wire [`DATA_W-1:0]  status;
	wire [`DATA_W-1:0]  magnitude;
	wire                rd_cur;
	wire                rd_vol;
	wire                rd_tmp;
	wire                rd_clear_all;
	wire                cfg_write;
	wire                gain_change;
	wire                exceeds;
	wire [`DATA_W-1:0]  cur_in;
	wire                set_cur;
	wire                set_vol;
	wire                set_tmp;
	wire                clr_vol;
	wire                clr_tmp;
	wire                mode_write;

	function hit;
		input [`ADDR_W-1:0] a;
		input [`ADDR_W-1:0] target;
		begin
			hit = (a == target);
		end
	endfunction

	function [`DATA_W-1:0] abs_mag;
		input [`DATA_W-1:0] v;
		begin
			abs_mag = v[`DATA_W-1] ? (~v + `WORD_ONE) : v;
		end
	endfunction

	function [`DATA_W-1:0] clamp_in;
		input               over;
		input               under;
		input [`DATA_W-1:0] sample;
		begin
			if (over)
				clamp_in = `POS_FULL;
			else if (under)
				clamp_in = `NEG_FULL;
			else
				clamp_in = sample;
		end
	endfunction

	overrange_tick u_tick (
		.clk    (clk),
		.resetn (resetn),
		.tick   (tick)
	);

	result_slot u_cur (
		.clk        (clk),
		.resetn     (resetn),
		.valid      (cur_valid),
		.over       (cur_over),
		.under      (cur_under),
		.sample     (cur_sample),
		.ready_flag (cur_rdy_reg),
		.core_down  (core_down),
		.accept     (cur_acc),
		.result_reg (cur_res),
		.error_reg  (cur_err)
	);

	result_slot u_vol (
		.clk        (clk),
		.resetn     (resetn),
		.valid      (vol_valid),
		.over       (vol_over),
		.under      (vol_under),
		.sample     (vol_sample),
		.ready_flag (vol_rdy_reg),
		.core_down  (core_down),
		.accept     (vol_acc),
		.result_reg (vol_res),
		.error_reg  (vol_err)
	);

	result_slot u_tmp (
		.clk        (clk),
		.resetn     (resetn),
		.valid      (tmp_valid),
		.over       (tmp_over),
		.under      (tmp_under),
		.sample     (tmp_sample),
		.ready_flag (tmp_rdy_reg),
		.core_down  (core_down),
		.accept     (tmp_acc),
		.result_reg (tmp_res),
		.error_reg  (tmp_err)
	);

	assign rd_cur = rd_en & hit(addr, `CURRENT_ADDR);
	assign rd_vol = rd_en & hit(addr, `VOLTAGE_ADDR);
	assign rd_tmp = rd_en & hit(addr, `TEMP_ADDR);
	assign rd_clear_all = rd_cur | (~cur_en & (rd_vol | rd_tmp));
	assign mode_write = wr_en & hit(addr, `MODE_ADDR);
	assign cfg_write = mode_write | (wr_en & hit(addr, `CONFIG_ADDR));
	assign gain_change = wr_en & hit(addr, `CURCTL_ADDR) &
		(wdata[`CTL_GAIN_MSB:`CTL_GAIN_LSB] != curctl_reg[`CTL_GAIN_MSB:`CTL_GAIN_LSB]);
	// Compare the arriving value; the result register still holds the last one
	assign cur_in = clamp_in(cur_over, cur_under, cur_sample);
	assign magnitude = abs_mag(cur_in);
	assign exceeds = magnitude > thresh_reg;
	assign set_cur = (cur_acc & cur_en) | cal_done;
	assign set_vol = (vol_acc & vol_en) | cal_done;
	assign set_tmp = (tmp_acc & tmp_en) | cal_done;
	assign clr_vol = rd_clear_all | rd_vol;
	assign clr_tmp = rd_clear_all | rd_tmp;

	// Reserved bits 11 to 5 tie to zero
	assign status = {cal_reg, tmp_err, vol_err, cur_err, 7'h00,
		cmp_reg, ovr_reg, tmp_rdy_reg, vol_rdy_reg, cur_rdy_reg};

	// Control registers; status word has no write path
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mask_reg   <= `MASK_RESET;
			mode_reg   <= `BYTE_ZERO;
			config_reg <= `BYTE_ZERO;
			curctl_reg <= `BYTE_ZERO;
			thresh_reg <= `WORD_ZERO;
			tcount_reg <= `BYTE_ZERO;
		end else if (wr_en) begin
			if (hit(addr, `MASK_ADDR))
				mask_reg <= wdata[7:0];
			else if (hit(addr, `MODE_ADDR))
				mode_reg <= wdata[7:0];
			else if (hit(addr, `CONFIG_ADDR))
				config_reg <= wdata[7:0];
			else if (hit(addr, `CURCTL_ADDR))
				curctl_reg <= wdata[7:0];
			else if (hit(addr, `THRESH_ADDR))
				thresh_reg <= wdata;
			else if (hit(addr, `TCOUNT_ADDR))
				tcount_reg <= wdata[7:0];
		end
	end

	// Ready flags: a set in the clearing cycle wins
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cur_rdy_reg <= 1'b0;
			vol_rdy_reg <= 1'b0;
			tmp_rdy_reg <= 1'b0;
		end else begin
			if (set_cur)
				cur_rdy_reg <= 1'b1;
			else if (rd_clear_all)
				cur_rdy_reg <= 1'b0;
			if (set_vol)
				vol_rdy_reg <= 1'b1;
			else if (clr_vol)
				vol_rdy_reg <= 1'b0;
			if (set_tmp)
				tmp_rdy_reg <= 1'b1;
			else if (clr_tmp)
				tmp_rdy_reg <= 1'b0;
		end
	end

	// Calibration flag; a finishing calibration beats the mode write
	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			cal_reg <= 1'b0;
		else if (cal_done)
			cal_reg <= 1'b1;
		else if (mode_write)
			cal_reg <= 1'b0;
	end

	// Comparator with optional hit counter
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmp_reg  <= 1'b0;
			hits_reg <= `COUNT_ZERO;
		end else if (cfg_write | ~config_reg[`CFG_CMP_EN]) begin
			cmp_reg  <= 1'b0;
			hits_reg <= `COUNT_ZERO;
		end else if (cur_acc & exceeds) begin
			if (!config_reg[`CFG_CNT_EN])
				cmp_reg <= 1'b1;
			else if (hits_reg + `COUNT_ONE == tcount_reg)
				cmp_reg <= 1'b1;
			if (hits_reg != tcount_reg)
				hits_reg <= hits_reg + `COUNT_ONE;
		end
	end

	// Overrange sampled on the divider tick, sticky until disabled or gain change
	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			ovr_reg <= 1'b0;
		else if (tick & fast_over & config_reg[`CFG_OVR_EN])
			ovr_reg <= 1'b1;
		else if (~config_reg[`CFG_OVR_EN] | gain_change)
			ovr_reg <= 1'b0;
	end

	// Registered read data and level interrupt
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= `WORD_ZERO;
			irq   <= 1'b0;
		end else begin
			irq <= |(status[7:0] & mask_reg);
			if (!rd_en)
				rdata <= `WORD_ZERO;
			else if (hit(addr, `STATUS_ADDR))
				rdata <= status;
			else if (hit(addr, `MASK_ADDR))
				rdata <= {`BYTE_ZERO, mask_reg};
			else if (hit(addr, `MODE_ADDR))
				rdata <= {`BYTE_ZERO, mode_reg};
			else if (rd_cur)
				rdata <= cur_res;
			else if (rd_vol)
				rdata <= vol_res;
			else if (rd_tmp)
				rdata <= tmp_res;
			else if (hit(addr, `CONFIG_ADDR))
				rdata <= {`BYTE_ZERO, config_reg};
			else if (hit(addr, `CURCTL_ADDR))
				rdata <= {`BYTE_ZERO, curctl_reg};
			else if (hit(addr, `THRESH_ADDR))
				rdata <= thresh_reg;
			else if (hit(addr, `TCOUNT_ADDR))
				rdata <= {`BYTE_ZERO, tcount_reg};
			else
				rdata <= `WORD_ZERO;
		end
	end
endmodule

// >>> sim/adc_status_irq_sva.sv
// Assertion checker for the converter status and interrupt block
`timescale 1ns/100ps
`include "adc_status_consts.vh"
module adc_status_irq_sva (
	input wire               clk,
	input wire               resetn,
	input wire [`ADDR_W-1:0] addr,
	input wire               rd_en,
	input wire               wr_en,
	input wire [`DATA_W-1:0] wdata,
	input wire [`DATA_W-1:0] rdata,
	input wire               irq,
	input wire               core_down,
	input wire               cur_valid,
	input wire               cur_over,
	input wire               cal_done
);
	reg [7:0] mask_reg;
	// Shadow of the mask so the interrupt can be tied to what software wrote
	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			mask_reg <= 8'h00;
		else if (wr_en && addr == `MASK_ADDR)
			mask_reg <= wdata[7:0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_rdata_idle: assert property (!rd_en |=> rdata == 16'h0000)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (rd_en && addr[31:8] != 24'hffff05 |=> rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_reserved_zero: assert property (rd_en && addr == `STATUS_ADDR |=> rdata[11:5] == 7'h00)
		else $error("reserved status bits not zero");
	a_cal_sets: assert property (cal_done ##1 (!rd_en && !wr_en) ##1 (rd_en && addr == `STATUS_ADDR)
		|=> rdata[15] && rdata[2:0] == 3'h7)
		else $error("calibration end flags missing");
	a_mode_clears: assert property (wr_en && addr == `MODE_ADDR && !cal_done
		##1 (!cal_done && !rd_en) ##1 (rd_en && addr == `STATUS_ADDR) |=> !rdata[15])
		else $error("mode write left calibration flag");
	a_err_sets: assert property (cur_valid && cur_over && core_down ##1 (!cur_valid && !rd_en)
		##1 (rd_en && addr == `STATUS_ADDR) |=> rdata[12])
		else $error("current range error flag missing");
	a_irq_gate: assert property (irq |-> $past(mask_reg) != 8'h00)
		else $error("interrupt with all sources masked");
	a_mask_back: assert property (rd_en && !wr_en && addr == `MASK_ADDR
		|=> rdata == {8'h00, $past(mask_reg)})
		else $error("mask readback mismatch");
	a_cur_clears: assert property (rd_en && addr == `CURRENT_ADDR && !cur_valid && !cal_done
		##1 (!cur_valid && !cal_done && !rd_en) ##1 (rd_en && addr == `STATUS_ADDR) |=> !rdata[0])
		else $error("current read left ready flag");
endmodule
bind adc_status_irq_logic adc_status_irq_sva chk_u (.clk(clk), .resetn(resetn), .addr(addr),
	.rd_en(rd_en), .wr_en(wr_en), .wdata(wdata), .rdata(rdata), .irq(irq), .core_down(core_down),
	.cur_valid(cur_valid), .cur_over(cur_over), .cal_done(cal_done));

// >>> sim/conv_source.sv
// Converter front-end model feeding results and calibration events
`timescale 1ns/100ps
module conv_source (
	input  wire        clk,
	output reg  [2:0]  valid,
	output reg  [2:0]  over,
	output reg  [2:0]  under,
	output reg  [15:0] sample,
	output reg         cal
);
	initial begin
		valid = 3'h0;
		over = 3'h0;
		under = 3'h0;
		sample = 16'h0000;
		cal = 1'b0;
	end
	// Sample is inverted after the pulse so a stale value never passes as fresh
	task send(input [1:0] ch, input [15:0] s, input ov, input un);
		begin
			@(posedge clk) #1;
			valid[ch] = 1'b1;
			over[ch] = ov;
			under[ch] = un;
			sample = s;
			@(posedge clk) #1;
			valid = 3'h0;
			over = 3'h0;
			under = 3'h0;
			sample = ~s;
		end
	endtask
	task calib;
		begin
			@(posedge clk) #1;
			cal = 1'b1;
			@(posedge clk) #1;
			cal = 1'b0;
		end
	endtask
endmodule

// >>> sim/adc_status_irq_logic_bench.sv
// Testbench for the converter status and interrupt block
`timescale 1ns/100ps
`include "adc_status_consts.vh"
module adc_status_irq_logic_bench;
	localparam [31:0] sta = `STATUS_ADDR;
	localparam [31:0] msk = `MASK_ADDR;
	localparam [31:0] cur = `CURRENT_ADDR;
	localparam [31:0] vol = `VOLTAGE_ADDR;
	localparam [31:0] cfg = `CONFIG_ADDR;
	reg               clk, resetn, rd_en, wr_en, core_down, cur_en, fast_over, vt_en;
	reg  [31:0]       addr;
	reg  [15:0]       wdata, d;
	wire [15:0]       rdata, smp;
	wire              irq, cal;
	wire [2:0]        vld, ovr, und;
	integer           error_cnt, n_checks, i;
	conv_source src_u (.clk(clk), .valid(vld), .over(ovr), .under(und), .sample(smp), .cal(cal));
	adc_status_irq_logic dut_u (.clk(clk), .resetn(resetn), .addr(addr), .rd_en(rd_en), .wr_en(wr_en),
		.wdata(wdata), .rdata(rdata), .irq(irq), .core_down(core_down), .cur_en(cur_en), .vol_en(vt_en),
		.tmp_en(vt_en), .cur_valid(vld[0]), .cur_over(ovr[0]), .cur_under(und[0]), .cur_sample(smp),
		.vol_valid(vld[1]), .vol_over(ovr[1]), .vol_under(und[1]), .vol_sample(smp),
		.tmp_valid(vld[2]), .tmp_over(ovr[2]), .tmp_under(und[2]), .tmp_sample(smp),
		.cal_done(cal), .fast_over(fast_over));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task chk(input string nm, input [15:0] e, input [15:0] g);
		begin
			n_checks = n_checks + 1;
			if (g !== e) begin
				error_cnt = error_cnt + 1;
				$display("wrong value %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task wr(input [31:0] a, input [15:0] v);
		begin
			@(posedge clk) #1;
			wr_en = 1'b1;
			addr = a;
			wdata = v;
			@(posedge clk) #1;
			wr_en = 1'b0;
		end
	endtask
	task rd(input [31:0] a);
		begin
			@(posedge clk) #1;
			rd_en = 1'b1;
			addr = a;
			@(posedge clk) #1;
			rd_en = 1'b0;
			d = rdata;
		end
	endtask
	task rc(input [31:0] a, input [15:0] e);
		begin
			rd(a);
			chk($sformatf("reg %h", a), e, d);
		end
	endtask
	task close_out;
		begin
			$display("checks %0d mismatches %0d", n_checks, error_cnt);
			if (error_cnt == 0 && n_checks > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	initial begin
		#600000;
		error_cnt = error_cnt + 1;
		close_out;
	end
	initial begin
		{resetn, rd_en, wr_en, core_down, fast_over} = 5'h00;
		cur_en = 1'b1;
		vt_en = 1'b1;
		addr = 32'h0000_0000;
		wdata = 16'h0000;
		error_cnt = 0;
		n_checks = 0;
		repeat (5) @(posedge clk);
		#1 resetn = 1'b1;
		rc(sta, 16'h0000);
		rc(msk, 16'h0000);
		rc(32'hffff0600, 16'h0000);
		$display("test reset done");
		src_u.calib;
		rc(sta, 16'h8007);
		wr(msk, 16'h0001);
		@(posedge clk) #1;
		chk("irq", 16'h0001, {15'h0000, irq});
		wr(sta, 16'h0000);
		rc(sta, 16'h8007);
		wr(`MODE_ADDR, 16'h0000);
		rc(sta, 16'h0007);
		rc(vol, 16'h0000);
		rc(sta, 16'h0005);
		rc(`TEMP_ADDR, 16'h0000);
		rc(sta, 16'h0001);
		wr(msk, 16'h00fe);
		@(posedge clk) #1;
		chk("irq", 16'h0000, {15'h0000, irq});
		wr(msk, 16'h0001);
		rc(cur, 16'h0000);
		rc(sta, 16'h0000);
		chk("irq", 16'h0000, {15'h0000, irq});
		src_u.calib;
		rc(cur, 16'h0000);
		rc(sta, 16'h8000);
		wr(msk, 16'h00ff);
		@(posedge clk) #1;
		chk("irq", 16'h0000, {15'h0000, irq});
		wr(`MODE_ADDR, 16'h0000);
		$display("test flags done");
		src_u.send(0, 16'h1234, 0, 0);
		src_u.send(0, 16'h5678, 0, 0);
		rc(cur, 16'h1234);
		core_down = 1'b1;
		src_u.send(0, 16'h2222, 1, 0);
		rc(sta, 16'h1001);
		rc(cur, 16'h7fff);
		src_u.send(0, 16'h3333, 0, 1);
		src_u.send(0, 16'h0100, 0, 0);
		rc(cur, 16'h0100);
		rc(sta, 16'h0000);
		src_u.send(1, 16'h0042, 0, 1);
		rc(vol, 16'h8000);
		rc(sta, 16'h2000);
		core_down = 1'b0;
		cur_en = 1'b0;
		src_u.send(1, 16'h0011, 0, 0);
		src_u.send(2, 16'h0022, 0, 0);
		rc(vol, 16'h0011);
		rc(sta, 16'h0000);
		cur_en = 1'b1;
		vt_en = 1'b0;
		src_u.send(2, 16'h0033, 0, 0);
		rc(sta, 16'h0000);
		rc(`TEMP_ADDR, 16'h0033);
		vt_en = 1'b1;
		$display("test results done");
		wr(`THRESH_ADDR, 16'h0100);
		wr(cfg, 16'h0001);
		src_u.send(0, 16'hfe00, 0, 0);
		rc(cur, 16'hfe00);
		rc(sta, 16'h0010);
		wr(cfg, 16'h0000);
		rc(sta, 16'h0000);
		wr(`TCOUNT_ADDR, 16'h0002);
		wr(cfg, 16'h0003);
		src_u.send(0, 16'h0200, 0, 0);
		rc(cur, 16'h0200);
		rc(sta, 16'h0000);
		src_u.send(0, 16'h0200, 0, 0);
		rc(cur, 16'h0200);
		rc(sta, 16'h0010);
		$display("test comparator done");
		wr(cfg, 16'h0004);
		fast_over = 1'b1;
		d = 16'h0000;
		// Polls for up to 15400 cycles, about 1.2 sampling periods, before giving up
		for (i = 0; i < 1400 && !d[3]; i = i + 1) begin
			repeat (9) @(posedge clk);
			rd(sta);
		end
		chk("overrange", 16'h0008, d);
		fast_over = 1'b0;
		repeat (12600) @(posedge clk);
		rc(sta, 16'h0008);
		wr(`CURCTL_ADDR, 16'h0001);
		rc(sta, 16'h0000);
		$display("test overrange done");
		close_out;
	end
endmodule
